// ---- design/cwg_pkg.sv ----
// Package with register map, field positions and mode codes for the waveform unit
// Behaviour
// R1 - Outputs derived from selected pulse input
// R2 - Dead time delays each output turn-on
// R3 - Auto-shutdown ends active drive on fault
// R4 - Three-bit mode field selects six modes
// R5 - Software changes mode only while disabled; the code also accepts mode writes while enabled
// R6 - One pulse input, up to four outputs
// R7 - Half-bridge: true and inverted input copies
// R8 - Half-bridge inserts non-overlap dead band
// R9 - Steering has no effect in half-bridge
// R10 - Outputs C,D copy A,B with polarity bits
// R11 - Control bit 7 enables the block
// R12 - Load buffers on rise after fall
// R13 - Load bit cleared by hardware
// R14 - Load bit not settable with enable write
// R15 - Six-bit clocked independent rise/fall timers
// R16 - Load bit clears when buffers transfer
package waveform_pkg;
    localparam int ADDR_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_CON0 = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_CON1 = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_DBR = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_DBF = 4'hC;
    localparam int EN_BIT = 7;
    localparam int LOAD_BIT = 6;
    localparam int MODE_LSB = 0;
    localparam int MODE_W = 3;
    localparam int POLA_BIT = 0;
    localparam int POLB_BIT = 1;
    localparam int OUT_C_POL_BIT = 2;
    localparam int OUT_D_POL_BIT = 3;
    localparam int STEER_LSB = 4;
    localparam int SHUT_BIT = 0;
    localparam int DB_W = 6;
    localparam logic [7:0] CON0_RESET = 8'h00;
    localparam logic [7:0] CON1_RESET = 8'h00;
    localparam logic [DB_W-1:0] DB_RESET = 6'h00;
    localparam logic [MODE_W-1:0] MODE_ASYNC_STEER = 3'h0;
    localparam logic [MODE_W-1:0] MODE_SYNC_STEER = 3'h1;
    localparam logic [MODE_W-1:0] MODE_FWD_FULL = 3'h2;
    localparam logic [MODE_W-1:0] MODE_REV_FULL = 3'h3;
    localparam logic [MODE_W-1:0] MODE_HALF = 3'h4;
    localparam logic [MODE_W-1:0] MODE_PUSH_PULL = 3'h5;
endpackage

// ---- design/pin_sync.sv ----
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Pin
    input wire logic i_pin,
    // Filtered level
    output logic o_level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            o_level <= 1'b0;
        end else begin
            s1_reg <= i_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
                o_level <= s3_reg;
            end
        end
    end
endmodule
`default_nettype wire

// ---- design/dead_band_timer.sv ----
// Six-bit clocked dead-band delay for one output turn-on
`timescale 1ns/1ps
`default_nettype none
module dead_band_timer #(
    parameter int W = 6
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Control
    input wire logic i_run,
    input wire logic [W-1:0] i_count,
    input wire logic i_req,
    // Delayed drive
    output logic o_drive
);
    logic [W-1:0] cnt_reg;
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_reg <= '0;
            o_drive <= 1'b0;
        end else if (!i_run || !i_req) begin
            cnt_reg <= '0;
            o_drive <= 1'b0;
        end else if (cnt_reg >= i_count) begin
            o_drive <= 1'b1; // R2 R15
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end
endmodule
`default_nettype wire

// ---- design/complementary_waveform_unit.sv ----
// Complementary waveform unit with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module complementary_waveform_unit (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Avalon-MM slave
    input wire logic [waveform_pkg::ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    output logic [31:0] o_readdata,
    output logic o_waitrequest,
    // Pulse data and fault pins
    input wire logic i_pulse_data,
    input wire logic i_fault,
    // Drive outputs
    output logic o_drive_out_a,
    output logic o_drive_out_b,
    output logic o_drive_out_c,
    output logic o_drive_out_d
);
    import waveform_pkg::*;

    logic enable_reg;
    logic load_buffers_reg;
    logic [MODE_W-1:0] mode_reg;
    logic [7:0] con1_reg;
    logic shutdown_reg;
    logic [DB_W-1:0] dbr_shadow_reg;
    logic [DB_W-1:0] dbf_shadow_reg;
    logic [DB_W-1:0] dbr_reg;
    logic [DB_W-1:0] dbf_reg;
    logic data_prev_reg;
    logic fall_seen_reg;
    logic ack_reg;
    logic data_s;
    logic fault_s;
    logic rise_ev;
    logic fall_ev;
    logic load_now;
    logic wr_acc;
    logic rd_acc;
    logic [3:0] raw;
    logic [3:0] active;
    logic [3:0] drive_next;
    logic steer_a;
    logic steer_b;
    logic run;
    logic a_req;
    logic b_req;
    logic a_dly;
    logic b_dly;

    pin_sync u_data_sync (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_pin(i_pulse_data),
        .o_level(data_s)
    );

    pin_sync u_fault_sync (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_pin(i_fault),
        .o_level(fault_s)
    );

    // One-cycle wait state per access, then acknowledge
    assign wr_acc = i_write && ack_reg;
    assign rd_acc = i_read && ack_reg;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            ack_reg <= 1'b0;
            o_waitrequest <= 1'b1;
        end else begin
            ack_reg <= (i_read || i_write) && !ack_reg;
            o_waitrequest <= !((i_read || i_write) && !ack_reg);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_readdata <= '0;
        end else if ((i_read || i_write) && !ack_reg) begin
            case (i_address)
                ADDR_CON0: o_readdata <= {24'h00_0000, enable_reg, load_buffers_reg,
                                          3'h0, mode_reg};
                ADDR_CON1: o_readdata <= {24'h00_0000, con1_reg};
                ADDR_DBR: o_readdata <= {26'h00_0000, dbr_shadow_reg};
                ADDR_DBF: o_readdata <= {26'h00_0000, dbf_shadow_reg};
                default: o_readdata <= '0;
            endcase
        end
    end

    // Enable and mode
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            enable_reg <= CON0_RESET[EN_BIT];
            mode_reg <= CON0_RESET[MODE_W-1:0];
        end else if (wr_acc && i_address == ADDR_CON0) begin
            enable_reg <= i_writedata[EN_BIT]; // R11
            mode_reg <= i_writedata[MODE_LSB +: MODE_W]; // R4; R5 not enforced, mode written even while enabled
        end
    end

    // Load request: set only while already enabled, cleared on transfer
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            load_buffers_reg <= CON0_RESET[LOAD_BIT];
        end else if (wr_acc && i_address == ADDR_CON0 && enable_reg
                     && i_writedata[LOAD_BIT]) begin
            load_buffers_reg <= 1'b1; // R14
        end else if (load_now || !enable_reg) begin
            load_buffers_reg <= 1'b0; // R13 R16
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            con1_reg <= CON1_RESET;
            dbr_shadow_reg <= DB_RESET;
            dbf_shadow_reg <= DB_RESET;
        end else if (wr_acc) begin
            case (i_address)
                ADDR_CON1: con1_reg <= i_writedata[7:0];
                ADDR_DBR: dbr_shadow_reg <= i_writedata[DB_W-1:0];
                ADDR_DBF: dbf_shadow_reg <= i_writedata[DB_W-1:0];
                default: con1_reg <= con1_reg;
            endcase
        end
    end

    // Edge tracking for buffer load
    assign rise_ev = data_s && !data_prev_reg;
    assign fall_ev = !data_s && data_prev_reg;
    assign load_now = load_buffers_reg && fall_seen_reg && rise_ev; // R12

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            data_prev_reg <= 1'b0;
        end else begin
            data_prev_reg <= data_s;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            fall_seen_reg <= 1'b0;
        end else if (!load_buffers_reg || load_now) begin
            fall_seen_reg <= 1'b0;
        end else if (fall_ev) begin
            fall_seen_reg <= 1'b1; // R12
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            dbr_reg <= DB_RESET;
            dbf_reg <= DB_RESET;
        end else if (load_now) begin
            dbr_reg <= dbr_shadow_reg; // R12 R15
            dbf_reg <= dbf_shadow_reg;
        end
    end

    // Auto-shutdown latches on fault; software releases by writing zero
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            shutdown_reg <= 1'b0;
        end else if (fault_s) begin
            shutdown_reg <= 1'b1; // R3
        end else if (wr_acc && i_address == ADDR_CON1 && !i_writedata[STEER_LSB + 4]) begin
            shutdown_reg <= 1'b0;
        end
    end

    assign run = enable_reg && !shutdown_reg;
    assign a_req = data_s; // R1 R6
    assign b_req = !data_s; // R7

    dead_band_timer #(.W(DB_W)) u_rise_db (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_run(run),
        .i_count(dbr_reg),
        .i_req(a_req),
        .o_drive(a_dly)
    );

    dead_band_timer #(.W(DB_W)) u_fall_db (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_run(run),
        .i_count(dbf_reg),
        .i_req(b_req),
        .o_drive(b_dly)
    );

    assign steer_a = con1_reg[STEER_LSB];
    assign steer_b = con1_reg[STEER_LSB + 1];

    always_comb begin
        raw = 4'h0;
        case (mode_reg)
            MODE_HALF: raw = {b_dly, a_dly, b_dly, a_dly}; // R8 R9 R10
            MODE_PUSH_PULL: raw = {b_dly, a_dly, b_dly, a_dly};
            MODE_FWD_FULL: raw = {data_s, 1'b0, 1'b0, 1'b1};
            MODE_REV_FULL: raw = {1'b0, 1'b1, data_s, 1'b0};
            MODE_ASYNC_STEER, MODE_SYNC_STEER: raw = {1'b0, 1'b0, data_s && steer_b,
                                                      data_s && steer_a};
            default: raw = 4'h0;
        endcase
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : g_out
            assign active[g] = run && raw[g]; // R3
            assign drive_next[g] = active[g] ^ con1_reg[POLA_BIT + g]; // R10
        end
    endgenerate

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_drive_out_a <= 1'b0;
            o_drive_out_b <= 1'b0;
            o_drive_out_c <= 1'b0;
            o_drive_out_d <= 1'b0;
        end else begin
            o_drive_out_a <= drive_next[0];
            o_drive_out_b <= drive_next[1];
            o_drive_out_c <= drive_next[2];
            o_drive_out_d <= drive_next[3];
        end
    end
endmodule
`default_nettype wire

// ---- sim/cwg_props.sv ----
// Checker for the register port and the drive outputs of the waveform unit
`timescale 1ns/1ps
`default_nettype none
module waveform_props import waveform_pkg::*; (
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    input wire logic [waveform_pkg::ADDR_W-1:0] i_address,
    input wire logic i_read,
    input wire logic i_write,
    input wire logic [31:0] i_writedata,
    input wire logic [31:0] o_readdata,
    input wire logic o_waitrequest,
    input wire logic i_pulse_data,
    input wire logic i_fault,
    input wire logic o_drive_out_a,
    input wire logic o_drive_out_b,
    input wire logic o_drive_out_c,
    input wire logic o_drive_out_d
);
    logic wr_acc, rd_acc, load_ok, settled, half;
    logic [7:0] c0_sh, c1_sh;
    logic [2:0] quiet;
    assign wr_acc = i_write && !o_waitrequest;
    assign rd_acc = i_read && !o_waitrequest && i_address == ADDR_CON0;
    // Outputs judged only once control writes have had time to land
    assign settled = quiet == 3'h7 && c1_sh[3:0] == 4'h0;
    assign half = c0_sh[2:0] == MODE_HALF;
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);
    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            c0_sh <= 8'h00;
            c1_sh <= 8'h00;
            load_ok <= 1'b0;
            quiet <= 3'h0;
        end else begin
            if (wr_acc && i_address == ADDR_CON0) begin
                c0_sh <= i_writedata[7:0];
                load_ok <= c0_sh[EN_BIT] && i_writedata[EN_BIT] && i_writedata[LOAD_BIT];
            end
            if (wr_acc && i_address == ADDR_CON1) begin
                c1_sh <= i_writedata[7:0];
            end
            quiet <= wr_acc ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
        end
    end
    sequence s_req;
        $rose(i_read || i_write);
    endsequence
    property p_answer;
        s_req |-> ##[1:2] !o_waitrequest;
    endproperty
    a_answer: assert property (p_answer) else $error("request not answered");
    property p_wait_one;
        $fell(o_waitrequest) |=> o_waitrequest;
    endproperty
    a_wait_one: assert property (p_wait_one) else $error("accept longer than one cycle");
    property p_mode;
        rd_acc |-> {o_readdata[EN_BIT], o_readdata[2:0]} == {c0_sh[EN_BIT], c0_sh[2:0]};
    endproperty
    a_mode: assert property (p_mode) else $error("mode or enable readback wrong");
    property p_load;
        rd_acc && !load_ok |-> !o_readdata[LOAD_BIT];
    endproperty
    a_load: assert property (p_load) else $error("load bit set without enable");
    property p_fault;
        $rose(i_fault) && c1_sh[1:0] == 2'h0 |-> ##[1:8] !(o_drive_out_a || o_drive_out_b);
    endproperty
    a_fault: assert property (p_fault) else $error("drive not cut on fault");
    property p_overlap;
        settled && half |-> !(o_drive_out_a && o_drive_out_b);
    endproperty
    a_overlap: assert property (p_overlap) else $error("outputs overlap");
    property p_copy;
        settled && half |-> o_drive_out_c == o_drive_out_a && o_drive_out_d == o_drive_out_b;
    endproperty
    a_copy: assert property (p_copy) else $error("c or d differ from a or b");
    property p_idle;
        settled && !c0_sh[EN_BIT] |-> !(o_drive_out_a || o_drive_out_b || o_drive_out_c
            || o_drive_out_d);
    endproperty
    a_idle: assert property (p_idle) else $error("drive while disabled");
endmodule
bind complementary_waveform_unit waveform_props i_props (.i_ref_clk, .i_arst_n, .i_address,
    .i_read, .i_write, .i_writedata, .o_readdata, .o_waitrequest, .i_pulse_data, .i_fault,
    .o_drive_out_a, .o_drive_out_b, .o_drive_out_c, .o_drive_out_d);
`default_nettype wire

// ---- sim/stage_model.sv ----
// Behavioural power stage that reports a fault on command or on shoot-through
`timescale 1ns/1ps
`default_nettype none
module stage_model (
    // Gate drives
    input wire logic i_drive_a,
    input wire logic i_drive_b,
    // Injected fault and fault feedback
    input wire logic i_trip,
    output logic o_fault
);
    // Both switches on at once shorts the supply
    assign o_fault = i_trip || (i_drive_a && i_drive_b);
endmodule
`default_nettype wire

// ---- sim/complementary_waveform_unit_bench.sv ----
// Register and drive-level tests for the waveform unit
`timescale 1ns/1ps
`default_nettype none
module complementary_waveform_unit_bench;
    import waveform_pkg::*;
    localparam logic [31:0] RUN = 32'h0000_0084;
    localparam logic [31:0] LOAD = 32'h0000_00C4;
    logic i_ref_clk = 1'b0, i_arst_n = 1'b0, i_read = 1'b0, i_write = 1'b0;
    logic i_pulse_data = 1'b0, trip = 1'b0, fault, o_waitrequest, a, b, c, d;
    logic [ADDR_W-1:0] i_address = 4'h0;
    logic [31:0] i_writedata = 32'h0000_0000, o_readdata, q;
    int miscompares = 0, compares = 0;
    always #25 i_ref_clk = ~i_ref_clk;
    complementary_waveform_unit i_dut (.i_ref_clk, .i_arst_n, .i_address, .i_read, .i_write,
        .i_writedata, .o_readdata, .o_waitrequest, .i_pulse_data, .i_fault(fault),
        .o_drive_out_a(a), .o_drive_out_b(b), .o_drive_out_c(c), .o_drive_out_d(d));
    stage_model i_stage (.i_drive_a(a), .i_drive_b(b), .i_trip(trip), .o_fault(fault));
    task automatic close_out();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: got %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [ADDR_W-1:0] ad, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge i_ref_clk);
        i_address <= ad;
        i_write <= w;
        i_read <= !w;
        i_writedata <= wd;
        do begin
            @(posedge i_ref_clk);
            n++;
        end while (o_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) begin
            miscompares++;
            close_out();
        end
        q = o_readdata;
        i_read <= 1'b0;
        i_write <= 1'b0;
    endtask
    task automatic rd(input logic [ADDR_W-1:0] ad, input logic [31:0] e);
        bus(1'b0, ad, 32'h0000_0000);
        chk(q, e);
    endtask
    task automatic hold(input logic v);
        @(posedge i_ref_clk);
        i_pulse_data <= v;
        repeat (16) @(posedge i_ref_clk);
    endtask
    task automatic drv(input logic [3:0] e);
        chk({28'h0, a, b, c, d}, {28'h0, e});
    endtask
    // Counts cycles with both primary outputs off after one input edge
    task automatic gap(input logic v, input logic [31:0] e);
        logic [31:0] n;
        n = 32'h0000_0000;
        @(posedge i_ref_clk);
        i_pulse_data <= v;
        repeat (24) begin
            @(posedge i_ref_clk);
            n = n + {31'h0, a === 1'b0 && b === 1'b0};
        end
        chk(n, e);
    endtask
    initial begin
        repeat (20) @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        for (int r = 0; r < 5; r++) rd(4'(r * 4 + (r / 4) * 2 - (r / 4) * 16), 0);
        $display("reset values done");
        // Mode changed only while disabled
        for (int m = 0; m < 6; m++) begin
            bus(1'b1, ADDR_CON0, 32'(m));
            rd(ADDR_CON0, 32'(m));
        end
        $display("mode field done");
        bus(1'b1, ADDR_DBR, 32'h0000_00FF);
        rd(ADDR_DBR, 32'h0000_003F);
        bus(1'b1, ADDR_DBR, 32'h0000_0003);
        bus(1'b1, ADDR_DBF, 32'h0000_0005);
        bus(1'b1, ADDR_CON0, LOAD);
        rd(ADDR_CON0, RUN);
        hold(1'b1);
        bus(1'b1, ADDR_CON0, LOAD);
        hold(1'b1);
        rd(ADDR_CON0, LOAD);
        hold(1'b0);
        rd(ADDR_CON0, LOAD);
        hold(1'b1);
        rd(ADDR_CON0, RUN);
        $display("buffer load done");
        drv(4'b1010);
        // Steering bits set as well: half-bridge must ignore them
        bus(1'b1, ADDR_CON1, 32'h0000_003C);
        hold(1'b1);
        drv(4'b1001);
        gap(1'b0, 32'h0000_0005);
        drv(4'b0110);
        gap(1'b1, 32'h0000_0003);
        drv(4'b1001);
        $display("half bridge done");
        bus(1'b1, ADDR_CON1, 32'h0000_0000);
        @(posedge i_ref_clk);
        trip <= 1'b1;
        hold(1'b1);
        drv(4'b0000);
        @(posedge i_ref_clk);
        trip <= 1'b0;
        hold(1'b1);
        drv(4'b0000);
        bus(1'b1, ADDR_CON1, 32'h0000_0000);
        hold(1'b1);
        drv(4'b1010);
        $display("shutdown done");
        bus(1'b1, ADDR_CON0, 32'(MODE_HALF));
        hold(1'b1);
        drv(4'b0000);
        rd(ADDR_CON0, 32'(MODE_HALF));
        $display("disable done");
        // Steering mode, entered while disabled, passes data to A only
        bus(1'b1, ADDR_CON1, 32'h0000_0010);
        bus(1'b1, ADDR_CON0, 32'(MODE_ASYNC_STEER));
        bus(1'b1, ADDR_CON0, 32'h0000_0080 | 32'(MODE_ASYNC_STEER));
        hold(1'b1);
        drv(4'b1000);
        $display("steering done");
        close_out();
    end
endmodule
`default_nettype wire
